/* File: tic_pkg.sv */
`default_nettype none
package tic_pkg;
  // clock rate and times in their own units
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned CLK_PER_MS   = CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_MS  = 20;
  localparam int unsigned LONG_OPEN_S  = 5;
  localparam int unsigned CNT_PULSE_MS = 100;
  localparam int unsigned FREE_ARM_MS  = 200;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * CLK_PER_MS;
  localparam int unsigned LONG_OPEN_CYC = LONG_OPEN_S * CLK_HZ;
  localparam int unsigned CNT_PULSE_CYC = CNT_PULSE_MS * CLK_PER_MS;
  localparam int unsigned FREE_ARM_CYC  = FREE_ARM_MS * CLK_PER_MS;
  localparam int TIM_W = 31;
  localparam int NUM_IN = 7;
  // input bit positions
  localparam int IN_SERVO = 0;
  localparam int IN_LEFT  = 1;
  localparam int IN_RIGHT = 2;
  localparam int IN_GEN   = 3;
  localparam int IN_CLIMB = 4;
  localparam int IN_CRAWL = 5;
  localparam int IN_LOCK  = 6;
  // register map
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PEND   = 8'h08;
  localparam int CTRL_ACTIVE_LOW = 0;
  localparam int CTRL_STORAGE    = 1;
  localparam logic [1:0] CTRL_RST    = 2'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] PEND_MAX    = 8'hFF;

  typedef enum logic [1:0] {EM_NORMAL, EM_FREE_ARM, EM_RELEASED} tic_emer_type;

  // status from the drive side, same clock
  typedef struct packed {
    logic obstruction;
    logic can_fault;
    logic hw_fault;
    logic sw_fault;
    logic power_fail;
    logic alarm_wire_break;
    logic home_pos;
    logic passed_left;
    logic passed_right;
  } tic_drive_type;

  // whole block state
  typedef struct packed {
    logic [NUM_IN-1:0]             sync1;
    logic [NUM_IN-1:0]             sync2;
    logic [NUM_IN-1:0]             filt;
    logic [NUM_IN-1:0][TIM_W-1:0]  db_cnt;
    logic [TIM_W-1:0]              hold_l;
    logic [TIM_W-1:0]              hold_r;
    logic                          perm_l;
    logic                          perm_r;
    logic [7:0]                    pend_l;
    logic [7:0]                    pend_r;
    logic [TIM_W-1:0]              cp_l;
    logic [TIM_W-1:0]              cp_r;
    tic_emer_type                  emer;
    logic [TIM_W-1:0]              emer_cnt;
    logic [1:0]                    ctrl;
    logic                          fault_ok;
    logic                          home;
    logic                          free_l;
    logic                          free_r;
    logic                          cnt_l;
    logic                          cnt_r;
    logic                          servo_en;
    logic                          lock_rel;
    logic                          magnet;
    logic                          motor_run;
    logic                          aw_full;
    logic                          w_full;
    logic [7:0]                    awaddr;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [1:0]                    rresp;
    logic [31:0]                   rdata;
  } tic_state_type;

  localparam tic_state_type STATE_RST = '0;
endpackage
`default_nettype wire

/* File: tic_io_control.sv */
// Function
// - inputs selectable active high or low
// - servo enabled only while servo emergency present
// - servo emergency loss releases drop arm
// - left pulse opens once, long holds open
// - right pulse opens once, long holds open
// - general emergency loss clears both directions
// - general loss: magnet off, free arm, release
// - lock blocks both directions, ignores pulses
// - servo emergency overrides lock
// - collective fault while any error persists
// - fault relay closed only without error
// - home output while in end position
// - free left output while left cleared
// - free right output while right cleared
// - left counter pulse per left passage
// - right counter pulse per right passage
// - pulse storage counts, holds open, decrements
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tic_io_control
  import tic_pkg::*;
#(
  parameter int unsigned DEBOUNCE_C  = DEBOUNCE_CYC,
  parameter int unsigned LONG_OPEN_C = LONG_OPEN_CYC,
  parameter int unsigned CNT_PULSE_C = CNT_PULSE_CYC,
  parameter int unsigned FREE_ARM_C  = FREE_ARM_CYC
) (
  input  wire logic                aclk,                // 250 MHz clock
  input  wire logic                aresetn,             // sync reset, low
  input  wire logic                servo_enable_emergency_in, // pin
  input  wire logic                open_left_in,        // pin
  input  wire logic                open_right_in,       // pin
  input  wire logic                general_emergency_in, // pin
  input  wire logic                climb_monitor_in,    // pin
  input  wire logic                crawl_monitor_in,    // pin
  input  wire logic                lock_both_dirs_in,   // pin
  input  wire tic_drive_type       drive_status,        // from drive logic
  output logic                     fault_relay_closed,  // high = no error
  output logic                     home_pos_out,        // end position
  output logic                     free_left_out,       // left cleared
  output logic                     free_right_out,      // right cleared
  output logic                     count_left_out,      // left counter pulse
  output logic                     count_right_out,     // right counter pulse
  output logic                     servo_release_signal, // servo drive enable
  output logic                     lock_release_out,    // lock opened
  output logic                     drop_arm_magnet_out, // magnet holds arm
  output logic                     motor_free_arm_out,  // brief freeing run
  input  wire logic [7:0]          s_axi_awaddr,        // write address
  input  wire logic                s_axi_awvalid,       // write addr valid
  output logic                     s_axi_awready,       // write addr ready
  input  wire logic [31:0]         s_axi_wdata,         // write data
  input  wire logic [3:0]          s_axi_wstrb,         // byte enables
  input  wire logic                s_axi_wvalid,        // write data valid
  output logic                     s_axi_wready,        // write data ready
  output logic [1:0]               s_axi_bresp,         // write response
  output logic                     s_axi_bvalid,        // response valid
  input  wire logic                s_axi_bready,        // response ready
  input  wire logic [7:0]          s_axi_araddr,        // read address
  input  wire logic                s_axi_arvalid,       // read addr valid
  output logic                     s_axi_arready,       // read addr ready
  output logic [31:0]              s_axi_rdata,         // read data
  output logic [1:0]               s_axi_rresp,         // read response
  output logic                     s_axi_rvalid,        // read valid
  input  wire logic                s_axi_rready         // read ready
);

  localparam logic [TIM_W-1:0] DB_LIM   = TIM_W'(DEBOUNCE_C);
  localparam logic [TIM_W-1:0] LONG_LIM = TIM_W'(LONG_OPEN_C);
  localparam logic [TIM_W-1:0] CP_LEN   = TIM_W'(CNT_PULSE_C);
  localparam logic [TIM_W-1:0] ARM_LEN  = TIM_W'(FREE_ARM_C);

  tic_state_type st_reg;
  tic_state_type st_next;

  logic [NUM_IN-1:0] pins;
  logic [NUM_IN-1:0] lvl;
  logic              servo_ok;
  logic              gen_ok;
  logic              locked;
  logic              rise_l;
  logic              rise_r;
  logic              fault;
  logic              wr_fire;
  logic              rd_fire;
  logic              wr_hit;
  logic              rd_hit;
  logic [31:0]       rd_val;

  assign pins = {lock_both_dirs_in, crawl_monitor_in, climb_monitor_in,
                 general_emergency_in, open_right_in, open_left_in,
                 servo_enable_emergency_in};

  // polarity applied after the second flop so the first stays clean
  assign lvl = st_reg.sync2 ^ {NUM_IN{st_reg.ctrl[CTRL_ACTIVE_LOW]}};

  // qualified levels, read straight from the filter register
  assign servo_ok = st_reg.filt[IN_SERVO];
  assign gen_ok   = st_reg.filt[IN_GEN];
  assign locked   = st_reg.filt[IN_LOCK];

  // climb or crawl attempts count as obstruction
  assign fault = drive_status.obstruction | st_reg.filt[IN_CLIMB]
               | st_reg.filt[IN_CRAWL] | !servo_ok | !gen_ok
               | drive_status.can_fault | drive_status.hw_fault
               | drive_status.sw_fault | drive_status.power_fail
               | drive_status.alarm_wire_break;

  // register read mux
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      ADDR_CTRL:   rd_val = {30'h0, st_reg.ctrl};
      ADDR_STATUS: rd_val = {19'h0, st_reg.emer, st_reg.perm_r,
                             st_reg.perm_l, fault, st_reg.filt, 1'b0};
      ADDR_PEND:   rd_val = {16'h0, st_reg.pend_r, st_reg.pend_l};
      default:     rd_hit = 1'b0;
    endcase
  end

  assign wr_fire = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
  assign wr_hit  = st_reg.awaddr == ADDR_CTRL;
  assign rd_fire = s_axi_arvalid && st_reg.arready;

  // all next-state logic
  always_comb
  begin
    st_next = st_reg;

    // two-flop synchroniser then stable-time filter
    st_next.sync1 = pins;
    st_next.sync2 = st_reg.sync1;
    for (int i = 0; i < NUM_IN; i++)
    begin
      if (lvl[i] == st_reg.filt[i])
        st_next.db_cnt[i] = '0;
      else if (st_reg.db_cnt[i] >= DB_LIM - 1'b1)
      begin
        st_next.filt[i]   = lvl[i];
        st_next.db_cnt[i] = '0;
      end
      else
        st_next.db_cnt[i] = st_reg.db_cnt[i] + 1'b1;
    end

    // a pulse counts once it has passed the filter
    rise_l = st_next.filt[IN_LEFT] && !st_reg.filt[IN_LEFT];
    rise_r = st_next.filt[IN_RIGHT] && !st_reg.filt[IN_RIGHT];

    // long hold measurement; permanent open lasts while held
    if (!st_reg.filt[IN_LEFT])
    begin
      st_next.hold_l = '0;
      st_next.perm_l = 1'b0;
    end
    else if (st_reg.hold_l >= LONG_LIM)
      st_next.perm_l = !locked;
    else
      st_next.hold_l = st_reg.hold_l + 1'b1;

    if (!st_reg.filt[IN_RIGHT])
    begin
      st_next.hold_r = '0;
      st_next.perm_r = 1'b0;
    end
    else if (st_reg.hold_r >= LONG_LIM)
      st_next.perm_r = !locked;
    else
      st_next.hold_r = st_reg.hold_r + 1'b1;

    // stored openings: a passage takes one, lock drops them all
    if (locked)
    begin
      st_next.pend_l = '0;
      st_next.pend_r = '0;
      st_next.perm_l = 1'b0;
      st_next.perm_r = 1'b0;
    end
    else
    begin
      if (drive_status.passed_left && st_reg.pend_l != '0)
        st_next.pend_l = st_reg.pend_l - 1'b1;
      if (rise_l)
      begin
        if (!st_reg.ctrl[CTRL_STORAGE])
          st_next.pend_l = (st_reg.pend_l == '0) ? 8'h01 : st_next.pend_l;
        else if (st_next.pend_l != PEND_MAX)
          st_next.pend_l = st_next.pend_l + 1'b1;
      end

      if (drive_status.passed_right && st_reg.pend_r != '0)
        st_next.pend_r = st_reg.pend_r - 1'b1;
      if (rise_r)
      begin
        if (!st_reg.ctrl[CTRL_STORAGE])
          st_next.pend_r = (st_reg.pend_r == '0) ? 8'h01 : st_next.pend_r;
        else if (st_next.pend_r != PEND_MAX)
          st_next.pend_r = st_next.pend_r + 1'b1;
      end
    end

    // general emergency: free the arm, then power down and unlock
    case (st_reg.emer)
      EM_NORMAL:
      begin
        st_next.emer_cnt = '0;
        if (!gen_ok)
          st_next.emer = EM_FREE_ARM;
      end
      EM_FREE_ARM:
      begin
        st_next.emer_cnt = st_reg.emer_cnt + 1'b1;
        if (gen_ok)
          st_next.emer = EM_NORMAL;
        else if (st_reg.emer_cnt >= ARM_LEN - 1'b1)
          st_next.emer = EM_RELEASED;
      end
      EM_RELEASED:
      begin
        st_next.emer_cnt = '0;
        if (gen_ok)
          st_next.emer = EM_NORMAL;
      end
      default:
        st_next.emer = EM_NORMAL;
    endcase

    // actuator outputs; servo loss stops all at once
    st_next.servo_en  = servo_ok && st_next.emer != EM_RELEASED;
    st_next.magnet    = servo_ok && gen_ok;
    st_next.motor_run = servo_ok && st_next.emer == EM_FREE_ARM;
    st_next.lock_rel  = !servo_ok || st_next.emer == EM_RELEASED;

    // clearance: emergencies outrank the lock, lock outranks pulses
    if (!servo_ok || !gen_ok)
    begin
      st_next.free_l = 1'b1;
      st_next.free_r = 1'b1;
    end
    else
    begin
      st_next.free_l = !locked && (st_next.pend_l != '0 || st_next.perm_l);
      st_next.free_r = !locked && (st_next.pend_r != '0 || st_next.perm_r);
    end

    // fail-safe relay and home position follow their causes
    st_next.fault_ok = !fault;
    st_next.home     = drive_status.home_pos;

    // counter pulses, retriggered by a new passage
    if (drive_status.passed_left)
      st_next.cp_l = CP_LEN;
    else if (st_reg.cp_l != '0)
      st_next.cp_l = st_reg.cp_l - 1'b1;

    if (drive_status.passed_right)
      st_next.cp_r = CP_LEN;
    else if (st_reg.cp_r != '0)
      st_next.cp_r = st_reg.cp_r - 1'b1;

    st_next.cnt_l = st_next.cp_l != '0;
    st_next.cnt_r = st_next.cp_r != '0;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && st_reg.awready)
    begin
      st_next.aw_full = 1'b1;
      st_next.awaddr  = s_axi_awaddr;
    end

    if (s_axi_wvalid && st_reg.wready)
    begin
      st_next.w_full = 1'b1;
      st_next.wdata  = s_axi_wdata;
      st_next.wstrb  = s_axi_wstrb;
    end

    if (wr_fire)
    begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (wr_hit && st_reg.wstrb[0])
        st_next.ctrl = st_reg.wdata[1:0];
    end
    else if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    // ready again once the pair is used
    st_next.awready = !st_next.aw_full;
    st_next.wready  = !st_next.w_full;

    // read channel: one outstanding read
    if (rd_fire)
    begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_val;
      st_next.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;

    st_next.arready = !st_next.rvalid;
  end

  // single state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= STATE_RST;
    else
      st_reg <= st_next;
  end

  assign fault_relay_closed   = st_reg.fault_ok;
  assign home_pos_out         = st_reg.home;
  assign free_left_out        = st_reg.free_l;
  assign free_right_out       = st_reg.free_r;
  assign count_left_out       = st_reg.cnt_l;
  assign count_right_out      = st_reg.cnt_r;
  assign servo_release_signal = st_reg.servo_en;
  assign lock_release_out     = st_reg.lock_rel;
  assign drop_arm_magnet_out  = st_reg.magnet;
  assign motor_free_arm_out   = st_reg.motor_run;
  assign s_axi_awready        = st_reg.awready;
  assign s_axi_wready         = st_reg.wready;
  assign s_axi_bvalid         = st_reg.bvalid;
  assign s_axi_bresp          = st_reg.bresp;
  assign s_axi_arready        = st_reg.arready;
  assign s_axi_rvalid         = st_reg.rvalid;
  assign s_axi_rdata          = st_reg.rdata;
  assign s_axi_rresp          = st_reg.rresp;

endmodule
`default_nettype wire

/* File: tic_access_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tic_access_model
  import tic_pkg::*;
(
  input  wire logic              active_low,   // reader wiring asserts at ground
  input  wire logic              interlock_en, // opposite-direction inhibit wired
  input  wire logic [NUM_IN-1:0] want,         // logical levels asked for
  input  wire logic              free_left,    // passage-free feedback left
  input  wire logic              free_right,   // passage-free feedback right
  output logic      [NUM_IN-1:0] pins          // levels at the input terminals
);
  logic [NUM_IN-1:0] gated;

  // a cleared direction holds back the other generator when the installer wires it
  always_comb
  begin
    gated = want;
    if (interlock_en && free_right)
      gated[IN_LEFT] = 1'b0;
    if (interlock_en && free_left)
      gated[IN_RIGHT] = 1'b0;
  end

  // asserted means supply or ground, depending on the installation
  assign pins = gated ^ {NUM_IN{active_low}};
endmodule
`default_nettype wire

/* File: tic_io_control_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tic_io_control_checker
  import tic_pkg::*;
#(
  parameter int unsigned CNT_PULSE_C = CNT_PULSE_CYC
) (
  input wire logic          aclk,                 // clock
  input wire logic          aresetn,              // sync reset, low
  input wire tic_drive_type drive_status,         // drive side status
  input wire logic          fault_relay_closed,   // no fault
  input wire logic          home_pos_out,         // end position
  input wire logic          free_left_out,        // left cleared
  input wire logic          free_right_out,       // right cleared
  input wire logic          count_left_out,       // left counter
  input wire logic          count_right_out,      // right counter
  input wire logic          servo_release_signal, // servo enabled
  input wire logic          lock_release_out,     // lock opened
  input wire logic          drop_arm_magnet_out,  // magnet holds arm
  input wire logic          motor_free_arm_out    // freeing run
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [TIM_W-1:0] len_l;
  logic [TIM_W-1:0] len_r;

  // running length of each counter pulse; a merged retrigger would read long
  always_ff @(posedge aclk)
  begin
    len_l <= (aresetn && count_left_out) ? len_l + 1'b1 : '0;
    len_r <= (aresetn && count_right_out) ? len_r + 1'b1 : '0;
  end

  // bits 8..3 of the drive status are the error levels
  a_fault_shown: assert property (|drive_status[8:3] |=> !fault_relay_closed)
    else $error("fault relay stayed closed during a drive error");
  a_home_follows: assert property ($past(aresetn) |-> home_pos_out == $past(drive_status.home_pos))
    else $error("home output does not follow the end position");
  a_count_left: assert property (drive_status.passed_left |=> count_left_out)
    else $error("no left counter pulse after a left passage");
  a_count_right: assert property (drive_status.passed_right |=> count_right_out)
    else $error("no right counter pulse after a right passage");
  a_len_left: assert property ($fell(count_left_out) |-> len_l == CNT_PULSE_C)
    else $error("left counter pulse has the wrong length");
  a_len_right: assert property ($fell(count_right_out) |-> len_r == CNT_PULSE_C)
    else $error("right counter pulse has the wrong length");
  a_magnet_off_run: assert property (motor_free_arm_out |-> !drop_arm_magnet_out)
    else $error("freeing run while the magnet still holds the arm");
  a_lock_after_stop: assert property ($rose(lock_release_out) |->
    !motor_free_arm_out && !servo_release_signal && !drop_arm_magnet_out)
    else $error("lock opened with motor or magnet still active");
  a_emer_frees: assert property ($rose(lock_release_out) |-> free_left_out && free_right_out)
    else $error("emergency release without both directions free");

  // main scenarios reached
  cover property ($fell(motor_free_arm_out));
  cover property ($fell(count_right_out));
  cover property (!fault_relay_closed ##1 fault_relay_closed);
endmodule
`default_nettype wire

/* File: tic_io_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tic_io_control_tb
  import tic_pkg::*;
;
  localparam int PULSE = 20;  // one reader pulse, inside the allowed width
  localparam int SETTLE = 12;  // sync, filter and output register with margin
  localparam logic [NUM_IN-1:0] IDLE = 7'h09;  // both emergency inputs present
  logic              aclk, aresetn, act_low;
  logic [NUM_IN-1:0] want, pins;
  tic_drive_type     drive_status;
  logic fault_relay_closed, home_pos_out, free_left_out, free_right_out, count_left_out;
  logic count_right_out, servo_release_signal, lock_release_out, drop_arm_magnet_out;
  logic motor_free_arm_out, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  int                fails, check_count;

  tic_access_model i_tic_access_model (.active_low(act_low), .interlock_en(1'b1),
    .want(want), .free_left(free_left_out), .free_right(free_right_out), .pins(pins));
  tic_io_control #(.DEBOUNCE_C(4), .LONG_OPEN_C(40), .CNT_PULSE_C(8), .FREE_ARM_C(6))
  i_tic_io_control (.aclk, .aresetn, .servo_enable_emergency_in(pins[IN_SERVO]),
    .open_left_in(pins[IN_LEFT]), .open_right_in(pins[IN_RIGHT]),
    .general_emergency_in(pins[IN_GEN]), .climb_monitor_in(pins[IN_CLIMB]),
    .crawl_monitor_in(pins[IN_CRAWL]), .lock_both_dirs_in(pins[IN_LOCK]), .drive_status,
    .fault_relay_closed, .home_pos_out, .free_left_out, .free_right_out, .count_left_out,
    .count_right_out, .servo_release_signal, .lock_release_out, .drop_arm_magnet_out,
    .motor_free_arm_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  // 250 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // write with both channels offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n++ < 50);
    chk(s_axi_bvalid, 1'b1, "bvalid");
    chk(s_axi_bresp, er, "bresp");
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n++ < 50);
    chk(s_axi_rvalid, 1'b1, "rvalid");
    rd_d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    axr(a);
    chk(rd_d, ed, "rdata");
    chk(s_axi_rresp, er, "rresp");
  endtask

  // one reader pulse followed by an equal quiet gap
  task automatic pulse(input int idx);
    want[idx] <= 1'b1;
    cyc(PULSE);
    want[idx] <= 1'b0;
    cyc(PULSE);
  endtask

  // one passage reported by the drive, then the counter pulse on that side
  task automatic pass_dir(input logic left);
    if (left)
      drive_status.passed_left <= 1'b1;
    else
      drive_status.passed_right <= 1'b1;
    cyc(1);
    drive_status.passed_left <= 1'b0;
    drive_status.passed_right <= 1'b0;
    cyc(1);
    chk(left ? count_left_out : count_right_out, 1'b1, "count pulse");
    cyc(10);
    chk({count_left_out, count_right_out}, 2'b00, "count ended");
  endtask

  task automatic t_regs;
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    axw(8'h0C, 32'h3, RESP_SLVERR);
    rd(8'h0C, 32'h0, RESP_SLVERR);
    axw(ADDR_STATUS, 32'h3, RESP_SLVERR);
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
  endtask

  // a second pulse while open is dropped, so one passage closes again
  task automatic t_left;
    pulse(IN_LEFT);
    chk(free_left_out, 1'b1, "free left");
    chk(free_right_out, 1'b0, "free right");
    pulse(IN_RIGHT);
    chk(free_right_out, 1'b0, "right held back");
    pulse(IN_LEFT);
    pass_dir(1'b1);
    chk(free_left_out, 1'b0, "free left closed");
  endtask

  task automatic t_long;
    want[IN_RIGHT] <= 1'b1;
    cyc(60);
    axr(ADDR_STATUS);
    chk(rd_d[10], 1'b1, "perm right");
    chk(rd_d[7:1], 7'h0D, "filtered inputs");
    pass_dir(1'b0);
    chk(free_right_out, 1'b1, "free right held");
    want[IN_RIGHT] <= 1'b0;
    cyc(SETTLE);
    chk(free_right_out, 1'b0, "free right ended");
  endtask

  task automatic t_store;
    axw(ADDR_CTRL, 32'h1 << CTRL_STORAGE, RESP_OKAY);
    pulse(IN_LEFT);
    pulse(IN_LEFT);
    rd(ADDR_PEND, 32'h2, RESP_OKAY);
    pass_dir(1'b1);
    chk(free_left_out, 1'b1, "free left stored");
    pass_dir(1'b1);
    chk(free_left_out, 1'b0, "free left empty");
    axw(ADDR_CTRL, 32'h0, RESP_OKAY);
  endtask

  task automatic t_lock;
    want[IN_LOCK] <= 1'b1;
    cyc(SETTLE);
    pulse(IN_LEFT);
    chk(free_left_out, 1'b0, "free left locked");
    want[IN_SERVO] <= 1'b0;
    cyc(SETTLE);
    chk({servo_release_signal, lock_release_out}, 2'b01, "servo lost");
    chk(drop_arm_magnet_out, 1'b0, "arm released");
    chk({free_left_out, free_right_out}, 2'b11, "open while locked");
    want <= IDLE;
    cyc(40);
    chk(servo_release_signal, 1'b1, "servo back");
  endtask

  task automatic t_gen;
    int n;
    want[IN_GEN] <= 1'b0;
    while (!motor_free_arm_out && n++ < 40) @(posedge aclk);
    chk(motor_free_arm_out, 1'b1, "free-arm run");
    chk(drop_arm_magnet_out, 1'b0, "magnet off");
    cyc(8);
    chk({motor_free_arm_out, servo_release_signal, lock_release_out}, 3'b001, "run over");
    chk({free_left_out, free_right_out}, 2'b11, "both free");
    chk(fault_relay_closed, 1'b0, "emergency fault");
    want <= IDLE;
    cyc(40);
  endtask

  // every drive error, then the two monitor inputs, then home position
  task automatic t_fault;
    for (int i = 3; i < 9; i++)
    begin
      drive_status <= tic_drive_type'(9'h1 << i);
      cyc(2);
      chk(fault_relay_closed, 1'b0, "drive fault");
      drive_status <= '0;
      cyc(2);
      chk(fault_relay_closed, 1'b1, "fault gone");
    end
    for (int i = IN_CLIMB; i <= IN_CRAWL; i++)
    begin
      want[i] <= 1'b1;
      cyc(SETTLE);
      chk(fault_relay_closed, 1'b0, "monitor fault");
      want[i] <= 1'b0;
      cyc(SETTLE);
    end
    drive_status.home_pos <= 1'b1;
    cyc(2);
    chk(home_pos_out, 1'b1, "home");
    drive_status <= '0;
  endtask

  // low-active wiring: the slow filter hides the short skew of the switch-over
  task automatic t_polar;
    axw(ADDR_CTRL, 32'h1 << CTRL_ACTIVE_LOW, RESP_OKAY);
    act_low <= 1'b1;
    cyc(40);
    chk(fault_relay_closed, 1'b1, "low-active idle");
    pulse(IN_LEFT);
    chk(free_left_out, 1'b1, "low-active open");
    pass_dir(1'b1);
  endtask

  task automatic complete_run;
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {aresetn, act_low, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    want = IDLE;
    drive_status = '0;
    fails = 0;
    check_count = 0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(40);
    chk({fault_relay_closed, servo_release_signal}, 2'b11, "idle");
    t_regs;
    t_left;
    t_long;
    t_store;
    t_lock;
    t_gen;
    t_fault;
    t_polar;
    complete_run;
  end

  // cut a hang short well after the whole sequence should be over
  initial
  begin
    cyc(20000);
    fails++;
    complete_run;
  end
endmodule

bind tic_io_control tic_io_control_checker #(.CNT_PULSE_C(CNT_PULSE_C)) i_tic_io_control_checker (
  .aclk, .aresetn, .drive_status, .fault_relay_closed, .home_pos_out, .free_left_out,
  .free_right_out, .count_left_out, .count_right_out, .servo_release_signal,
  .lock_release_out, .drop_arm_magnet_out, .motor_free_arm_out);
`default_nettype wire
